// [aps_host_model.sv]
// Purpose: Host-side model that issues moves and reports completion
// Assumes: One move at a time, started by a request level from the bench
// Notes: Released lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module aps_host_model (
  input wire logic pclk,
  input wire logic req,
  input wire logic [aps_pkg::POS_W-1:0] req_target,
  input wire logic req_contact,
  input wire logic move_go,
  output logic move_cmd,
  output logic [aps_pkg::POS_W-1:0] move_target,
  output logic move_done,
  output logic press_contact,
  output logic busy
);
  int n;
  initial begin
    move_cmd = 1'h0;
    move_target = 4'h0;
    move_done = 1'h0;
    press_contact = 1'h0;
    busy = 1'h0;
    forever begin
      @(posedge pclk);
      if (req && !busy) begin
        busy <= 1'h1;
        move_cmd <= 1'h1;
        move_target <= req_target;
        @(posedge pclk);
        move_cmd <= 1'h0;
        n = 0;
        // Waits for the start pulse; the bench watchdog ends a hang
        while (move_go !== 1'h1) begin
          @(posedge pclk);
          n++;
        end
        // Keeps done well clear of the table read
        repeat (2) @(posedge pclk);
        move_done <= 1'h1;
        press_contact <= req_contact;
        move_target <= ~move_target;
        @(posedge pclk);
        move_done <= 1'h0;
        press_contact <= ~req_contact;
        busy <= 1'h0;
      end
    end
  end
endmodule
`default_nettype wire

// [aps_pkg.sv]
// Purpose: Shared constants for the actuator power-saving control block
// Assumes: 125 MHz pclk, 32-bit APB register bus
// Notes: Register offsets are byte addresses
package aps_pkg;
  localparam int unsigned CLK_KHZ = 125000;
  localparam int unsigned SEC_MS = 1000;
  localparam int unsigned HALF_MS = 500;
  localparam int unsigned BUZZ_MS = 1000;
  localparam int unsigned SEC_CYCLES = SEC_MS * CLK_KHZ;
  localparam int unsigned HALF_CYCLES = HALF_MS * CLK_KHZ;
  localparam int unsigned BUZZ_CYCLES = BUZZ_MS * CLK_KHZ;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DELAY1 = 8'h04;
  localparam logic [7:0] OFS_DELAY2 = 8'h08;
  localparam logic [7:0] OFS_DELAY3 = 8'h0C;
  localparam logic [7:0] OFS_GMODE = 8'h10;
  localparam logic [7:0] OFS_TADDR = 8'h14;
  localparam logic [7:0] OFS_TDATA = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;

  localparam int unsigned CTRL_PULSE = 0;
  localparam int unsigned CTRL_THREE = 1;
  localparam int unsigned CTRL_INPOS = 2;
  localparam int unsigned CTRL_HIGH = 3;
  localparam int unsigned CTRL_ALT = 4;
  localparam int unsigned CTRL_W = 5;

  localparam int unsigned DLY_W = 16;
  localparam int unsigned CODE_W = 3;
  localparam int unsigned POS_W = 4;

  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam logic [DLY_W-1:0] DELAY_RST = 16'h0000;
  localparam logic [CODE_W-1:0] GMODE_RST = 3'h0;
  localparam logic [CODE_W-1:0] CODE_HOLD = 3'h0;
  localparam logic [CODE_W-1:0] CODE_FULL = 3'h4;

  typedef enum logic [2:0] {
    ST_HOLD = 3'b000,
    ST_MOVE = 3'b001,
    ST_WAIT_OFF = 3'b010,
    ST_FULL = 3'b011,
    ST_FULL_WAIT = 3'b100,
    ST_OFF = 3'b101
  } aps_state_t;
endpackage

// [aps_power_save.sv]
// Purpose: Servo power-saving sequencer, completion outputs and panel lamps
// Assumes: Motion inputs are one-cycle pulses synchronous to pclk
// Notes: Long counts are parameters so simulation can shorten them
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Auto servo-off after delay, next move re-enables
// - Three delay settings in whole seconds
// - Code 0 keeps servo; 1-3 delayed off
// - Code 4 holds full-servo indefinitely
// - Codes 5-7 full-servo then servo off
// - Base patterns: power-up, home before any move use global
// - Base patterns: positions use table stop mode
// - Alternative patterns: power-up uses global code
// - No servo-off after press with contact
// - Complete-mode flag: outputs low during off
// - In-position mode: outputs stay during off
// - Servo lamp flashes while auto off
// - No auto servo-off in pulse mode
// - Power lamp on, alarm lamp on error
// - Home lamp blinks; gate manual and teach
// - Registration buzzes one second, lamp flashes
// - Two- and three-point lamps follow setting
// - Accessory present disables high output
// - Pulse mode: 0-3 on, 4-7 full-servo
module aps_power_save #(
  parameter int unsigned SEC_CYC = aps_pkg::SEC_CYCLES,
  parameter int unsigned HALF_CYC = aps_pkg::HALF_CYCLES,
  parameter int unsigned BUZZ_CYC = aps_pkg::BUZZ_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic move_cmd,
  input wire logic [aps_pkg::POS_W-1:0] move_target,
  input wire logic move_done,
  input wire logic press_contact,
  input wire logic power_up_done,
  input wire logic home_done,
  input wire logic in_position,
  input wire logic error,
  input wire logic accessory_present,
  input wire logic panel_register,
  input wire logic manual_req,
  input wire logic teach_req,
  output logic move_go,
  output logic servo_enable,
  output logic full_servo,
  output logic completion_flag,
  output logic [aps_pkg::POS_W-1:0] completed_position_code,
  output logic current_position_flag,
  output logic servo_status_lamp,
  output logic power_lamp,
  output logic alarm_lamp,
  output logic home_lamp,
  output logic save_lamp,
  output logic buzzer,
  output logic two_point_lamp,
  output logic three_point_lamp,
  output logic high_output_en,
  output logic manual_grant,
  output logic teach_grant
);
  localparam logic [31:0] SEC_LAST = 32'(SEC_CYC - 1);
  localparam logic [31:0] HALF_LAST = 32'(HALF_CYC - 1);
  localparam logic [31:0] BUZZ_LAST = 32'(BUZZ_CYC - 1);

  // Maps a stop code to the state entered at the stop
  function automatic aps_pkg::aps_state_t code_state(input logic [aps_pkg::CODE_W-1:0] code,
                                                     input logic pulse);
    if (pulse) begin
      code_state = code[2] ? aps_pkg::ST_FULL : aps_pkg::ST_HOLD;
    end else if (code == aps_pkg::CODE_HOLD) begin
      code_state = aps_pkg::ST_HOLD;
    end else if (code == aps_pkg::CODE_FULL) begin
      code_state = aps_pkg::ST_FULL;
    end else begin
      code_state = code[2] ? aps_pkg::ST_FULL_WAIT : aps_pkg::ST_WAIT_OFF;
    end
  endfunction

  // Register file
  logic [aps_pkg::CTRL_W-1:0] ctrl_ff, nxt_ctrl;
  logic [aps_pkg::DLY_W-1:0] dly_ff [1:3];
  logic [aps_pkg::DLY_W-1:0] nxt_dly [1:3];
  logic [aps_pkg::CODE_W-1:0] gmode_ff, nxt_gmode;
  logic [aps_pkg::POS_W-1:0] taddr_ff, nxt_taddr;
  logic [aps_pkg::CODE_W-1:0] tbl_rd, pos_code;
  logic wr_acc, tbl_wr, hit;
  logic [31:0] rd_mux;
  aps_pkg::aps_state_t state_ff, nxt_state;
  logic home_ff;

  assign wr_acc = psel && penable && pwrite;
  assign tbl_wr = wr_acc && paddr == aps_pkg::OFS_TDATA;
  assign pready = 1'b1;

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_dly = dly_ff;
    nxt_gmode = gmode_ff;
    nxt_taddr = taddr_ff;
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      aps_pkg::OFS_CTRL: rd_mux[aps_pkg::CTRL_W-1:0] = ctrl_ff;
      aps_pkg::OFS_DELAY1: rd_mux[aps_pkg::DLY_W-1:0] = dly_ff[1];
      aps_pkg::OFS_DELAY2: rd_mux[aps_pkg::DLY_W-1:0] = dly_ff[2];
      aps_pkg::OFS_DELAY3: rd_mux[aps_pkg::DLY_W-1:0] = dly_ff[3];
      aps_pkg::OFS_GMODE: rd_mux[aps_pkg::CODE_W-1:0] = gmode_ff;
      aps_pkg::OFS_TADDR: rd_mux[aps_pkg::POS_W-1:0] = taddr_ff;
      aps_pkg::OFS_TDATA: rd_mux[aps_pkg::CODE_W-1:0] = tbl_rd;
      aps_pkg::OFS_STATUS: rd_mux[7:0] = {alarm_lamp, home_ff, full_servo, servo_enable,
                                          1'b0, state_ff};
      default: hit = 1'b0;
    endcase
    if (wr_acc) begin
      case (paddr)
        aps_pkg::OFS_CTRL: nxt_ctrl = pwdata[aps_pkg::CTRL_W-1:0];
        aps_pkg::OFS_DELAY1: nxt_dly[1] = pwdata[aps_pkg::DLY_W-1:0];
        aps_pkg::OFS_DELAY2: nxt_dly[2] = pwdata[aps_pkg::DLY_W-1:0];
        aps_pkg::OFS_DELAY3: nxt_dly[3] = pwdata[aps_pkg::DLY_W-1:0];
        aps_pkg::OFS_GMODE: nxt_gmode = pwdata[aps_pkg::CODE_W-1:0];
        aps_pkg::OFS_TADDR: nxt_taddr = pwdata[aps_pkg::POS_W-1:0];
        default: nxt_ctrl = ctrl_ff;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= aps_pkg::CTRL_RST;
      dly_ff[1] <= aps_pkg::DELAY_RST;
      dly_ff[2] <= aps_pkg::DELAY_RST;
      dly_ff[3] <= aps_pkg::DELAY_RST;
      gmode_ff <= aps_pkg::GMODE_RST;
      taddr_ff <= '0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      dly_ff <= nxt_dly;
      gmode_ff <= nxt_gmode;
      taddr_ff <= nxt_taddr;
      // Read data and error present from the access phase on
      prdata <= (psel && !penable && !pwrite) ? rd_mux : prdata;
      pslverr <= (psel && !penable) ? !hit : pslverr;
    end
  end

  logic [aps_pkg::POS_W-1:0] tgt_ff, nxt_tgt;

  aps_stop_table u_table (
    .pclk(pclk),
    .wr_en(tbl_wr),
    .wr_addr(taddr_ff),
    .wr_data(pwdata[aps_pkg::CODE_W-1:0]),
    .rd_addr_a(tgt_ff),
    .rd_data_a(pos_code),
    .rd_addr_b(taddr_ff),
    .rd_data_b(tbl_rd)
  );

  // Power-saving sequencer
  logic [31:0] cyc_ff, nxt_cyc;
  logic [aps_pkg::DLY_W-1:0] sec_ff, nxt_sec;
  logic [1:0] dsel_ff, nxt_dsel;
  logic [aps_pkg::POS_W-1:0] done_pos_ff, nxt_done_pos;
  logic moved_ff, nxt_moved, nxt_home, valid_ff, nxt_valid;
  logic pulse_mode, alt_pat, stop_evt, pos_evt, expire;
  logic [aps_pkg::CODE_W-1:0] eff_code;
  logic [aps_pkg::DLY_W-1:0] cur_dly;

  assign pulse_mode = ctrl_ff[aps_pkg::CTRL_PULSE];
  assign alt_pat = ctrl_ff[aps_pkg::CTRL_ALT];
  assign pos_evt = move_done && state_ff == aps_pkg::ST_MOVE;
  assign cur_dly = (dsel_ff == 2'd0) ? '0 : dly_ff[dsel_ff];
  assign expire = sec_ff >= cur_dly;

  always_comb begin
    nxt_state = state_ff;
    nxt_cyc = cyc_ff;
    nxt_sec = sec_ff;
    nxt_dsel = dsel_ff;
    nxt_tgt = tgt_ff;
    nxt_done_pos = done_pos_ff;
    nxt_moved = moved_ff;
    nxt_home = home_ff || home_done;
    nxt_valid = valid_ff;
    stop_evt = 1'b0;
    eff_code = aps_pkg::CODE_HOLD;
    // global code for power-up and home before any move
    // alternative patterns skip home, use global at power-up
    if (power_up_done || (home_done && !moved_ff && !alt_pat)) begin
      stop_evt = 1'b1;
      eff_code = gmode_ff;
    end
    // table stop mode after a positioning move
    if (pos_evt) begin
      stop_evt = 1'b1;
      eff_code = pos_code;
    end
    if (move_cmd) begin
      // wake servo and start the move
      nxt_state = aps_pkg::ST_MOVE;
      nxt_tgt = move_target;
      nxt_moved = 1'b1;
      nxt_valid = 1'b0;
      nxt_dsel = 2'd0;
    end else if (pos_evt && press_contact) begin
      // press with contact keeps servo as is
      nxt_state = aps_pkg::ST_HOLD;
      nxt_done_pos = tgt_ff;
      nxt_valid = 1'b1;
    end else if (stop_evt) begin
      // pulse mode never enters a servo-off path
      nxt_state = code_state(eff_code, pulse_mode);
      // delay index from code low bits
      nxt_dsel = eff_code[1:0];
      nxt_cyc = '0;
      nxt_sec = '0;
      if (pos_evt) begin
        nxt_done_pos = tgt_ff;
        nxt_valid = 1'b1;
      end
    end else if (state_ff == aps_pkg::ST_WAIT_OFF || state_ff == aps_pkg::ST_FULL_WAIT) begin
      if (expire) begin
        nxt_state = aps_pkg::ST_OFF;
      end else if (cyc_ff == SEC_LAST) begin
        nxt_cyc = '0;
        nxt_sec = sec_ff + 1'b1;
      end else begin
        nxt_cyc = cyc_ff + 32'd1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= aps_pkg::ST_HOLD;
      cyc_ff <= '0;
      sec_ff <= '0;
      dsel_ff <= 2'd0;
      tgt_ff <= '0;
      done_pos_ff <= '0;
      moved_ff <= 1'b0;
      home_ff <= 1'b0;
      valid_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cyc_ff <= nxt_cyc;
      sec_ff <= nxt_sec;
      dsel_ff <= nxt_dsel;
      tgt_ff <= nxt_tgt;
      done_pos_ff <= nxt_done_pos;
      moved_ff <= nxt_moved;
      home_ff <= nxt_home;
      valid_ff <= nxt_valid;
    end
  end

  // Outputs and panel
  logic [31:0] half_ff, nxt_half, buzz_ff, nxt_buzz;
  logic blink_ff, nxt_blink, save_ff, nxt_save;
  logic nxt_comp, nxt_curf, nxt_servo, nxt_full, nxt_go, nxt_alarm, nxt_svl, inpos_mode;
  logic [aps_pkg::POS_W-1:0] nxt_code;

  assign inpos_mode = ctrl_ff[aps_pkg::CTRL_INPOS];
  assign buzzer = buzz_ff != 32'd0;
  assign save_lamp = save_ff && blink_ff;
  assign home_lamp = home_ff && blink_ff;
  // manual moves and teaching need home done
  assign manual_grant = manual_req && home_ff;
  assign teach_grant = teach_req && home_ff;
  assign two_point_lamp = !ctrl_ff[aps_pkg::CTRL_THREE];
  assign three_point_lamp = ctrl_ff[aps_pkg::CTRL_THREE];
  assign high_output_en = ctrl_ff[aps_pkg::CTRL_HIGH] && !accessory_present;

  always_comb begin
    nxt_half = (half_ff == HALF_LAST) ? '0 : half_ff + 32'd1;
    nxt_blink = (half_ff == HALF_LAST) ? !blink_ff : blink_ff;
    nxt_buzz = (buzz_ff != 32'd0) ? buzz_ff - 32'd1 : buzz_ff;
    nxt_save = save_ff;
    // one second buzz, lamp starts flashing
    if (panel_register && home_ff) begin
      nxt_buzz = BUZZ_CYC;
      nxt_save = 1'b1;
    end
    nxt_servo = nxt_state != aps_pkg::ST_OFF;
    nxt_full = nxt_state == aps_pkg::ST_FULL || nxt_state == aps_pkg::ST_FULL_WAIT;
    nxt_go = move_cmd;
    nxt_alarm = error;
    // flash while auto off, steady otherwise
    nxt_svl = nxt_servo ? 1'b1 : nxt_blink;
    if (inpos_mode) begin
      nxt_comp = in_position;
      nxt_curf = nxt_valid && in_position;
    end else begin
      // completion view drops during servo off
      nxt_comp = nxt_valid && nxt_servo;
      nxt_curf = nxt_valid && nxt_servo;
    end
    nxt_code = nxt_curf ? nxt_done_pos : '0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_ff <= '0;
      blink_ff <= 1'b0;
      buzz_ff <= '0;
      save_ff <= 1'b0;
      servo_enable <= 1'b1;
      full_servo <= 1'b0;
      move_go <= 1'b0;
      alarm_lamp <= 1'b0;
      servo_status_lamp <= 1'b1;
      completion_flag <= 1'b0;
      current_position_flag <= 1'b0;
      completed_position_code <= '0;
      power_lamp <= 1'b0;
    end else begin
      half_ff <= nxt_half;
      blink_ff <= nxt_blink;
      buzz_ff <= nxt_buzz;
      save_ff <= nxt_save;
      servo_enable <= nxt_servo;
      full_servo <= nxt_full;
      move_go <= nxt_go;
      alarm_lamp <= nxt_alarm;
      servo_status_lamp <= nxt_svl;
      completion_flag <= nxt_comp;
      current_position_flag <= nxt_curf;
      completed_position_code <= nxt_code;
      power_lamp <= 1'b1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_move_wakes_servo: assert property (move_cmd |=> servo_enable && move_go ##1 !move_go)
    else $error("move command did not wake servo");
  a_delay_not_early: assert property ((state_ff == aps_pkg::ST_WAIT_OFF && !move_cmd && !expire)
    |=> state_ff == aps_pkg::ST_WAIT_OFF)
    else $error("servo-off before delay elapsed");
  a_code0_keeps_on: assert property ((stop_evt && !move_cmd && !press_contact
    && eff_code == aps_pkg::CODE_HOLD) |=> state_ff == aps_pkg::ST_HOLD && servo_enable)
    else $error("code 0 changed servo");
  a_code4_full: assert property ((stop_evt && !move_cmd && !pos_evt && eff_code == aps_pkg::CODE_FULL)
    |=> full_servo && servo_enable)
    else $error("code 4 missed full servo");
  a_full_then_off: assert property ((state_ff == aps_pkg::ST_FULL_WAIT && expire && !move_cmd)
    |=> !servo_enable && !full_servo)
    else $error("full servo did not end in servo off");
  a_table_code: assert property (pos_evt |-> eff_code == pos_code)
    else $error("position stop mode not used");
  a_press_no_off: assert property ((pos_evt && press_contact && !move_cmd)
    |=> state_ff == aps_pkg::ST_HOLD [*2])
    else $error("press contact led to power saving");
  a_off_flags_low: assert property ((!servo_enable && !$past(inpos_mode))
    |-> !completion_flag && !current_position_flag && completed_position_code == '0)
    else $error("completion outputs high during servo off");
  a_inpos_kept: assert property (inpos_mode |=> completion_flag == $past(in_position))
    else $error("in-position flag wrong");
  a_pulse_no_off: assert property ((pulse_mode && stop_evt && !move_cmd)
    |=> servo_enable && state_ff != aps_pkg::ST_WAIT_OFF)
    else $error("servo-off path in pulse mode");
  a_alarm_lamp: assert property (error |=> alarm_lamp)
    else $error("alarm lamp not lit");
  a_manual_gate: assert property ((manual_grant || teach_grant) |-> home_ff)
    else $error("manual allowed before home");
  a_high_gate: assert property (accessory_present |-> !high_output_en)
    else $error("high output with accessory");

  c_auto_off: cover property (state_ff == aps_pkg::ST_WAIT_OFF ##[1:300] !servo_enable);
  c_wake_from_off: cover property (!servo_enable && move_cmd ##1 servo_enable);
  c_full_hold: cover property (state_ff == aps_pkg::ST_FULL ##1 state_ff == aps_pkg::ST_FULL);
endmodule
`default_nettype wire

// [aps_power_save_tb.sv]
// Purpose: Self-checking bench for the power-saving sequencer
// Assumes: Short counts; stop table holds code N at position N
// Notes: Delays are 1, 2 and 3 seconds
`timescale 1ns/1ps
`default_nettype none
module aps_power_save_tb;
  localparam int SC = 10;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic power_up_done = 1'h0, home_done = 1'h0, in_position = 1'h0, error = 1'h0;
  logic accessory_present = 1'h0, panel_register = 1'h0, manual_req = 1'h0, teach_req = 1'h0;
  logic req = 1'h0, req_contact = 1'h0, busy, move_cmd, move_done, press_contact;
  logic [3:0] req_target = 4'h0, move_target, completed_position_code;
  logic pready, pslverr, move_go, servo_enable, full_servo, completion_flag;
  logic current_position_flag, servo_status_lamp, power_lamp, alarm_lamp, home_lamp;
  logic save_lamp, buzzer, two_point_lamp, three_point_lamp, high_output_en;
  logic manual_grant, teach_grant;
  int n_fail = 0, tests_run = 0;
  always #4 pclk = ~pclk;
  aps_power_save #(.SEC_CYC(SC), .HALF_CYC(4), .BUZZ_CYC(8)) i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .move_cmd, .move_target, .move_done, .press_contact, .power_up_done, .home_done,
    .in_position, .error, .accessory_present, .panel_register, .manual_req, .teach_req,
    .move_go, .servo_enable, .full_servo, .completion_flag, .completed_position_code,
    .current_position_flag, .servo_status_lamp, .power_lamp, .alarm_lamp, .home_lamp,
    .save_lamp, .buzzer, .two_point_lamp, .three_point_lamp, .high_output_en,
    .manual_grant, .teach_grant
  );
  aps_host_model i_host (
    .pclk, .req, .req_target, .req_contact, .move_go, .move_cmd, .move_target,
    .move_done, .press_contact, .busy
  );
  task automatic end_of_test();
    if (n_fail == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    // Only the watchdog ends a wait for the answer
    while (pready !== 1'h1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'h1, a, d, r, e);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic ee);
    logic [31:0] r;
    logic e;
    apb(1'h0, a, 32'h0, r, e);
    chk(r, exp);
    chk(32'(e), 32'(ee));
  endtask
  task automatic pulse(input int sel);
    @(posedge pclk);
    power_up_done <= sel == 0;
    home_done <= sel == 1;
    panel_register <= sel == 2;
    @(posedge pclk);
    {power_up_done, home_done, panel_register} <= 3'h0;
  endtask
  function automatic logic pick(input int sel);
    return sel == 0 ? servo_status_lamp : sel == 1 ? home_lamp : sel == 2 ? save_lamp : buzzer;
  endfunction
  // Counts changes and high cycles of one lamp or the buzzer
  task automatic tog(input int sel, input int cyc, output int cnt, output int hi);
    logic p;
    cnt = 0;
    hi = 0;
    p = pick(sel);
    repeat (cyc) begin
      @(posedge pclk);
      if (pick(sel) !== p) cnt++;
      if (pick(sel) === 1'h1) hi++;
      p = pick(sel);
    end
  endtask
  task automatic mv(input logic [3:0] t, input logic c);
    @(posedge pclk);
    req <= 1'h1;
    req_target <= t;
    req_contact <= c;
    @(posedge pclk);
    req <= 1'h0;
    @(posedge pclk);
    while (busy !== 1'h0) begin
      @(posedge pclk);
    end
  endtask
  // Margins of a few cycles absorb the bench's own handshake lag
  task automatic stop_chk(input int c);
    int d, t, h;
    d = (c % 4) * SC;
    mv(4'(c), 1'h0);
    chk(32'(completion_flag), 32'h1);
    chk(32'(completed_position_code), 32'(c));
    repeat (d > 3 ? d - 3 : 30) @(posedge pclk);
    chk(32'(servo_enable), 32'h1);
    chk(32'(full_servo), 32'(c >= 4));
    repeat (6) @(posedge pclk);
    chk(32'(servo_enable), 32'(d == 0));
    chk(32'(full_servo), 32'(c == 4));
    chk(32'(completion_flag), 32'(d == 0));
    chk(32'(current_position_flag), 32'(d == 0));
    chk(32'(completed_position_code), d == 0 ? 32'(c) : 32'h0);
    if (d > 0) begin
      tog(0, 10, t, h);
      chk(32'(t >= 2), 32'h1);
    end
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    end_of_test();
  end
  initial begin
    int c, h;
    repeat (3) @(posedge pclk);
    chk(32'(servo_enable), 32'h1);
    chk(32'(power_lamp), 32'h0);
    presetn <= 1'h1;
    repeat (2) @(posedge pclk);
    chk(32'(power_lamp), 32'h1);
    rdc(aps_pkg::OFS_CTRL, 32'(aps_pkg::CTRL_RST), 1'h0);
    rdc(aps_pkg::OFS_GMODE, 32'(aps_pkg::GMODE_RST), 1'h0);
    rdc(8'h20, 32'h0, 1'h1);
    wr(aps_pkg::OFS_DELAY1, 32'h1);
    wr(aps_pkg::OFS_DELAY2, 32'h2);
    wr(aps_pkg::OFS_DELAY3, 32'hABCD0003);
    rdc(aps_pkg::OFS_DELAY3, 32'h3, 1'h0);
    for (int i = 0; i < 8; i++) begin
      wr(aps_pkg::OFS_TADDR, 32'(i));
      wr(aps_pkg::OFS_TDATA, 32'(i));
    end
    rdc(aps_pkg::OFS_TDATA, 32'h7, 1'h0);
    wr(aps_pkg::OFS_GMODE, 32'h4);
    manual_req <= 1'h1;
    pulse(0);
    repeat (5) @(posedge pclk);
    chk(32'(full_servo), 32'h1);
    chk(32'(manual_grant), 32'h0);
    tog(1, 10, c, h);
    chk(32'(h), 32'h0);
    wr(aps_pkg::OFS_GMODE, 32'h1);
    pulse(1);
    teach_req <= 1'h1;
    repeat (SC + 5) @(posedge pclk);
    chk(32'(servo_enable), 32'h0);
    chk(32'({manual_grant, teach_grant}), 32'h3);
    tog(1, 10, c, h);
    chk(32'(c >= 2), 32'h1);
    for (int k = 0; k < 8; k++) stop_chk(k);
    mv(4'h3, 1'h0);
    repeat (5) @(posedge pclk);
    mv(4'h0, 1'h0);
    repeat (40) @(posedge pclk);
    chk(32'(servo_enable), 32'h1);
    mv(4'h1, 1'h1);
    repeat (2 * SC) @(posedge pclk);
    chk(32'(servo_enable), 32'h1);
    wr(aps_pkg::OFS_CTRL, 32'h4);
    in_position <= 1'h1;
    mv(4'h1, 1'h0);
    repeat (SC + 5) @(posedge pclk);
    chk(32'(servo_enable), 32'h0);
    chk(32'({completion_flag, current_position_flag}), 32'h3);
    chk(32'(completed_position_code), 32'h1);
    wr(aps_pkg::OFS_CTRL, 32'h1);
    for (int k = 1; k < 8; k += 4) begin
      mv(4'(k), 1'h0);
      repeat (2 * SC) @(posedge pclk);
      chk(32'(servo_enable), 32'h1);
      chk(32'(full_servo), 32'(k == 5));
    end
    for (int k = 0; k < 2; k++) begin
      wr(aps_pkg::OFS_CTRL, 32'(8 + 2 * k));
      @(posedge pclk);
      chk(32'({two_point_lamp, three_point_lamp}), k ? 32'h1 : 32'h2);
      chk(32'(high_output_en), 32'h1);
      accessory_present <= 1'h1;
      repeat (2) @(posedge pclk);
      chk(32'(high_output_en), 32'h0);
      accessory_present <= 1'h0;
    end
    error <= 1'h1;
    repeat (3) @(posedge pclk);
    chk(32'(alarm_lamp), 32'h1);
    error <= 1'h0;
    repeat (3) @(posedge pclk);
    chk(32'(alarm_lamp), 32'h0);
    pulse(2);
    tog(3, 15, c, h);
    chk(32'(h), 32'h8);
    tog(2, 10, c, h);
    chk(32'(c >= 1), 32'h1);
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    wr(aps_pkg::OFS_CTRL, 32'h10);
    wr(aps_pkg::OFS_GMODE, 32'h4);
    pulse(0);
    repeat (5) @(posedge pclk);
    chk(32'(full_servo), 32'h1);
    end_of_test();
  end
endmodule
`default_nettype wire

// [aps_stop_table.sv]
// Purpose: Per-position stop-mode table, one write and two registered reads
// Assumes: Read data lag the address by one clock
// Notes: Contents are not reset; software loads them before use
`timescale 1ns/1ps
`default_nettype none
module aps_stop_table (
  input wire logic pclk,
  input wire logic wr_en,
  input wire logic [aps_pkg::POS_W-1:0] wr_addr,
  input wire logic [aps_pkg::CODE_W-1:0] wr_data,
  input wire logic [aps_pkg::POS_W-1:0] rd_addr_a,
  output logic [aps_pkg::CODE_W-1:0] rd_data_a,
  input wire logic [aps_pkg::POS_W-1:0] rd_addr_b,
  output logic [aps_pkg::CODE_W-1:0] rd_data_b
);
  logic [aps_pkg::CODE_W-1:0] mem [0:(1<<aps_pkg::POS_W)-1];

  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_a <= mem[rd_addr_a];
    rd_data_b <= mem[rd_addr_b];
  end
endmodule
`default_nettype wire
